/* interval_timer.sv */
// Decided for this implementation: the address map and the AHB-Lite interface to the registers.
`timescale 1ns/10ps
`include "interval_timer_cfg.svh"
// Notes on behaviour
// [RULE1] sixteen-bit up counter in two bytes, steps per prescaled tick while on
// [RULE2] software write to either count byte replaces that byte at once
// [RULE3] on bit 0 enables counting; clearing halts and clears gate flip-flop
// [RULE4] bit 1 picks system clock when 1, system clock over four when 0
// [RULE5] system clock at 1:1 gives four counts per instruction cycle
// [RULE6] prescale bits 5:4 divide by 1, 2, 4 or 8
// [RULE7] counter steps once per prescaler output pulse
// [RULE8] prescale counter hidden from software, cleared on any count byte write
// [RULE9] FFFF wraps to 0000 and sets rollover flag bit 0
// [RULE10] interrupt needs timer on, rollover, peripheral and global enables
// [RULE11] rollover flag sticks until software clears it; clearing drops request
// [RULE12] software should clear count and flag before enabling interrupts
// [RULE13] timer frozen in sleep and never wakes the device
// [RULE14] control bits 7,6,3,2 read zero; others read/write, zero at reset
// [RULE15] byte write keeps the other byte; counting resumes from written value
module interval_timer #(
	parameter int COUNT_WIDTH = 16
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// ahb-lite slave
	input wire logic hsel,
	input wire logic [7:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// device state
	input wire logic sleep_mode,
	// interrupt request
	output logic irq
);

	interval_timer_pkg::timer_state_t st_reg;
	interval_timer_pkg::timer_state_t st_next;

	logic addr_phase;
	logic wr_now;
	interval_timer_pkg::reg_sel_t wr_sel;
	logic wr_low;
	logic wr_high;
	logic inst_tick;
	logic src_tick;
	logic run;
	logic step;

	// the state struct carries a sixteen-bit count; no other width fits
	if (COUNT_WIDTH != 16) begin : g_width_check
		$error("interval_timer supports only a sixteen-bit count");
	end

	// map a byte address onto a register; unmapped gives none
	function automatic interval_timer_pkg::reg_sel_t decode(
		input logic [7:0] a
	);
		interval_timer_pkg::reg_sel_t s;
		s = interval_timer_pkg::SEL_NONE;
		unique case (a)
			`OFS_CONTROL: s = interval_timer_pkg::SEL_CONTROL;
			`OFS_COUNT_LOW: s = interval_timer_pkg::SEL_LOW;
			`OFS_COUNT_HIGH: s = interval_timer_pkg::SEL_HIGH;
			`OFS_FLAG: s = interval_timer_pkg::SEL_FLAG;
			`OFS_ENABLE: s = interval_timer_pkg::SEL_ENABLE;
			`OFS_GLOBAL: s = interval_timer_pkg::SEL_GLOBAL;
			default: s = interval_timer_pkg::SEL_NONE;
		endcase
		return s;
	endfunction : decode

	// last prescale count before an output pulse
	function automatic logic [2:0] divide_max(input logic [1:0] ps);
		logic [2:0] m;
		m = 3'h0;
		unique case (ps)
			2'b00: m = 3'h0;
			2'b01: m = 3'h1;
			2'b10: m = 3'h3;
			2'b11: m = 3'h7;
		endcase
		return m;
	endfunction : divide_max

	always_comb begin
		addr_phase = hsel && htrans[1] && hready;
		wr_now = st_reg.req.act && st_reg.req.wr;
		wr_sel = wr_now ? decode(st_reg.req.addr)
			: interval_timer_pkg::SEL_NONE;
		wr_low = (wr_sel == interval_timer_pkg::SEL_LOW);
		wr_high = (wr_sel == interval_timer_pkg::SEL_HIGH);
		// instruction clock is one system clock in four
		inst_tick = (st_reg.phase == 2'(`INSTR_DIV - 3'h1));
		src_tick = st_reg.ctrl.clock_source_select ? 1'b1 : inst_tick; // [RULE4]
		// system clock stops in sleep, so run is held low then and the count stays put
		run = st_reg.ctrl.timer_on_bit && st_reg.gate && !sleep_mode; // [RULE3] [RULE13]
		step = run && src_tick
			&& (st_reg.pre_cnt == divide_max(st_reg.ctrl.prescale_select)); // [RULE6] [RULE7]
	end

	always_comb begin
		st_next = st_reg;
		if (!sleep_mode) begin
			st_next.phase = st_reg.phase + 2'h1;
		end
		st_next.gate = st_reg.ctrl.timer_on_bit; // [RULE3]
		if (run && src_tick) begin
			st_next.pre_cnt = step ? 3'h0 : st_reg.pre_cnt + 3'h1; // [RULE7]
		end
		if (step) begin
			st_next.count = st_reg.count + 16'h0001; // [RULE1] [RULE5]
			if (st_reg.count == `COUNT_TOP) begin
				st_next.rollover_flag = 1'b1; // [RULE9]
			end
		end
		// data phase of a write; a count write beats a same-cycle step
		unique case (wr_sel)
			interval_timer_pkg::SEL_CONTROL: begin
				st_next.ctrl.timer_on_bit = hwdata[`POS_TIMER_ON];
				st_next.ctrl.clock_source_select = hwdata[`POS_CLOCK_SOURCE];
				st_next.ctrl.prescale_select =
					hwdata[`POS_PRESCALE_HI:`POS_PRESCALE_LO]; // [RULE6] [RULE14]
			end
			interval_timer_pkg::SEL_LOW: begin
				st_next.count = {st_reg.count[15:8], hwdata[7:0]}; // [RULE2] [RULE15]
				st_next.pre_cnt = 3'h0; // [RULE8]
			end
			interval_timer_pkg::SEL_HIGH: begin
				st_next.count = {hwdata[7:0], st_reg.count[7:0]}; // [RULE2] [RULE15]
				st_next.pre_cnt = 3'h0; // [RULE8]
			end
			interval_timer_pkg::SEL_FLAG: begin
				// write one to clear; a rollover in the same cycle wins
				if (hwdata[`POS_ROLLOVER] && !(step
					&& st_reg.count == `COUNT_TOP)) begin
					st_next.rollover_flag = 1'b0; // [RULE11]
				end
			end
			interval_timer_pkg::SEL_ENABLE: begin
				st_next.rollover_interrupt_enable = hwdata[`POS_ROLLOVER];
			end
			interval_timer_pkg::SEL_GLOBAL: begin
				st_next.peripheral_interrupt_enable = hwdata[`POS_PERIPH_IE];
				st_next.global_interrupt_enable = hwdata[`POS_GLOBAL_IE];
			end
			default: begin
			end
		endcase
		// address phase; read data is sampled now, so a read right
		// behind a write to the same register sees the old value
		st_next.req.act = addr_phase;
		st_next.req.wr = hwrite;
		st_next.req.addr = haddr;
		if (addr_phase && !hwrite) begin
			st_next.rdata = `RST_WORD;
			unique case (decode(haddr))
				interval_timer_pkg::SEL_CONTROL: begin
					st_next.rdata[`POS_TIMER_ON] = st_reg.ctrl.timer_on_bit;
					st_next.rdata[`POS_CLOCK_SOURCE] =
						st_reg.ctrl.clock_source_select;
					st_next.rdata[`POS_PRESCALE_HI:`POS_PRESCALE_LO] =
						st_reg.ctrl.prescale_select; // [RULE14]
				end
				interval_timer_pkg::SEL_LOW: begin
					st_next.rdata[7:0] = st_reg.count[7:0];
				end
				interval_timer_pkg::SEL_HIGH: begin
					st_next.rdata[7:0] = st_reg.count[15:8];
				end
				interval_timer_pkg::SEL_FLAG: begin
					st_next.rdata[`POS_ROLLOVER] = st_reg.rollover_flag;
				end
				interval_timer_pkg::SEL_ENABLE: begin
					st_next.rdata[`POS_ROLLOVER] =
						st_reg.rollover_interrupt_enable;
				end
				interval_timer_pkg::SEL_GLOBAL: begin
					st_next.rdata[`POS_PERIPH_IE] =
						st_reg.peripheral_interrupt_enable;
					st_next.rdata[`POS_GLOBAL_IE] = st_reg.global_interrupt_enable;
				end
				default: begin
				end
			endcase
		end
		st_next.ready = 1'b1;
		st_next.resp = 1'b0;
		// all four enables and the flag, taken from the values being stored
		st_next.irq = st_next.rollover_flag
			&& st_next.rollover_interrupt_enable
			&& st_next.peripheral_interrupt_enable
			&& st_next.global_interrupt_enable
			&& st_next.ctrl.timer_on_bit; // [RULE10] [RULE11]
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			st_reg <= '0;
			st_reg.count <= `RST_COUNT;
			st_reg.rdata <= `RST_WORD;
			st_reg.ready <= 1'b1;
		end else begin
			st_reg <= st_next;
		end
	end

	assign hrdata = st_reg.rdata;
	assign hreadyout = st_reg.ready;
	assign hresp = st_reg.resp;
	assign irq = st_reg.irq;

	chk_count_step_only: assert property ( // [RULE1]
		@(posedge clk) disable iff (!rst_b)
		(!$past(wr_low || wr_high) && st_reg.count != $past(st_reg.count))
		|-> st_reg.count == $past(st_reg.count) + 16'h0001)
		else $error("count moved by other than one");

	chk_low_byte_write: assert property ( // [RULE2] [RULE15]
		@(posedge clk) disable iff (!rst_b)
		wr_low |=> st_reg.count[7:0] == $past(hwdata[7:0])
		&& st_reg.count[15:8] == $past(st_reg.count[15:8]))
		else $error("low byte write not applied");

	chk_high_byte_write: assert property ( // [RULE2] [RULE15]
		@(posedge clk) disable iff (!rst_b)
		wr_high |=> st_reg.count[15:8] == $past(hwdata[7:0])
		&& st_reg.count[7:0] == $past(st_reg.count[7:0]))
		else $error("high byte write not applied");

	chk_off_holds_count: assert property ( // [RULE3]
		@(posedge clk) disable iff (!rst_b)
		(!st_reg.ctrl.timer_on_bit && !wr_low && !wr_high)
		|=> $stable(st_reg.count) && !st_reg.gate)
		else $error("count moved while timer off");

	chk_gate_follows_on: assert property ( // [RULE3]
		@(posedge clk) disable iff (!rst_b)
		st_reg.gate == $past(st_reg.ctrl.timer_on_bit))
		else $error("gate flop did not follow on bit");

	chk_fast_four_counts: assert property ( // [RULE4] [RULE5]
		@(posedge clk) disable iff (!rst_b)
		(st_reg.ctrl == 4'b0011 && st_reg.gate && !sleep_mode
		&& !wr_low && !wr_high)[*5]
		|-> st_reg.count == $past(st_reg.count, 4) + 16'h0004)
		else $error("fast source did not give four counts");

	chk_slow_source_tick: assert property ( // [RULE4]
		@(posedge clk) disable iff (!rst_b)
		(step && !st_reg.ctrl.clock_source_select)
		|-> st_reg.phase == 2'(`INSTR_DIV - 3'h1))
		else $error("slow source stepped off its instruction tick");

	chk_prescale_pulse: assert property ( // [RULE6] [RULE7]
		@(posedge clk) disable iff (!rst_b)
		(!$past(wr_low || wr_high) && st_reg.count != $past(st_reg.count))
		|-> $past(st_reg.pre_cnt)
		== divide_max($past(st_reg.ctrl.prescale_select)))
		else $error("count stepped without prescaler pulse");

	chk_ctrl_write: assert property ( // [RULE6]
		@(posedge clk) disable iff (!rst_b)
		wr_sel == interval_timer_pkg::SEL_CONTROL
		|=> st_reg.ctrl.prescale_select
		== $past(hwdata[`POS_PRESCALE_HI:`POS_PRESCALE_LO])
		&& st_reg.ctrl.clock_source_select
		== $past(hwdata[`POS_CLOCK_SOURCE])
		&& st_reg.ctrl.timer_on_bit == $past(hwdata[`POS_TIMER_ON]))
		else $error("control write not applied");

	chk_prescale_cleared: assert property ( // [RULE8]
		@(posedge clk) disable iff (!rst_b)
		(wr_low || wr_high) |=> st_reg.pre_cnt == 3'h0)
		else $error("prescaler not cleared on count write");

	chk_low_byte_read: assert property ( // [RULE1]
		@(posedge clk) disable iff (!rst_b)
		(addr_phase && !hwrite && haddr == `OFS_COUNT_LOW)
		|=> hrdata == {24'h00_0000, $past(st_reg.count[7:0])})
		else $error("low byte read wrong");

	chk_high_byte_read: assert property ( // [RULE1]
		@(posedge clk) disable iff (!rst_b)
		(addr_phase && !hwrite && haddr == `OFS_COUNT_HIGH)
		|=> hrdata == {24'h00_0000, $past(st_reg.count[15:8])})
		else $error("high byte read wrong");

	chk_wrap_sets_flag: assert property ( // [RULE9]
		@(posedge clk) disable iff (!rst_b)
		(step && st_reg.count == `COUNT_TOP && !wr_low && !wr_high)
		|=> st_reg.count == 16'h0000 && st_reg.rollover_flag)
		else $error("wrap did not set rollover flag");

	chk_irq_needs_all: assert property ( // [RULE10]
		@(posedge clk) disable iff (!rst_b)
		$rose(irq) |-> st_reg.rollover_flag && st_reg.ctrl.timer_on_bit
		&& st_reg.rollover_interrupt_enable
		&& st_reg.peripheral_interrupt_enable
		&& st_reg.global_interrupt_enable
		&& $past(wr_now || step))
		else $error("interrupt raised without its cause");

	chk_irq_gated: assert property ( // [RULE10]
		@(posedge clk) disable iff (!rst_b)
		(!st_reg.rollover_flag || !st_reg.rollover_interrupt_enable
		|| !st_reg.peripheral_interrupt_enable
		|| !st_reg.global_interrupt_enable || !st_reg.ctrl.timer_on_bit)
		|-> !irq)
		else $error("interrupt raised with a condition missing");

	chk_flag_clear_cause: assert property ( // [RULE11]
		@(posedge clk) disable iff (!rst_b)
		$fell(st_reg.rollover_flag)
		|-> $past(wr_sel == interval_timer_pkg::SEL_FLAG && hwdata[0])
		&& !irq)
		else $error("rollover flag dropped without software clear");

	chk_flag_sticky: assert property ( // [RULE11]
		@(posedge clk) disable iff (!rst_b)
		(st_reg.rollover_flag && !(wr_sel == interval_timer_pkg::SEL_FLAG
		&& hwdata[`POS_ROLLOVER])) |=> st_reg.rollover_flag)
		else $error("rollover flag dropped on its own");

	chk_sleep_freeze: assert property ( // [RULE13]
		@(posedge clk) disable iff (!rst_b)
		(sleep_mode && !wr_low && !wr_high) |=> $stable(st_reg.count)
		&& $stable(st_reg.pre_cnt))
		else $error("timer moved during sleep");

	chk_sleep_phase: assert property ( // [RULE13]
		@(posedge clk) disable iff (!rst_b)
		sleep_mode |=> $stable(st_reg.phase))
		else $error("instruction phase moved during sleep");

	chk_ctrl_reserved: assert property ( // [RULE14]
		@(posedge clk) disable iff (!rst_b)
		(addr_phase && !hwrite && haddr == `OFS_CONTROL)
		|=> hrdata[7:6] == 2'b00 && hrdata[3:2] == 2'b00)
		else $error("reserved control bits read nonzero");

endmodule : interval_timer

/* interval_timer_cfg.svh */
`ifndef INTERVAL_TIMER_CFG_SVH
`define INTERVAL_TIMER_CFG_SVH

// register byte offsets on the bus
`define OFS_CONTROL 8'h00
`define OFS_COUNT_LOW 8'h04
`define OFS_COUNT_HIGH 8'h08
`define OFS_FLAG 8'h0C
`define OFS_ENABLE 8'h10
`define OFS_GLOBAL 8'h14

// field positions
`define POS_TIMER_ON 0
`define POS_CLOCK_SOURCE 1
`define POS_PRESCALE_LO 4
`define POS_PRESCALE_HI 5
`define POS_ROLLOVER 0
`define POS_PERIPH_IE 6
`define POS_GLOBAL_IE 7

// reset values and the top count before the wrap
`define RST_COUNT 16'h0000
`define RST_WORD 32'h0000_0000
`define COUNT_TOP 16'hFFFF

// instruction clock is the system clock divided by this many cycles
`define INSTR_DIV 3'h4

`endif

/* interval_timer_pkg.sv */
package interval_timer_pkg;

	typedef struct packed {
		logic [1:0] prescale_select;
		logic clock_source_select;
		logic timer_on_bit;
	} timer_ctrl_t;

	typedef struct packed {
		logic act;
		logic wr;
		logic [7:0] addr;
	} bus_req_t;

	typedef enum logic [2:0] {
		SEL_NONE = 3'b000,
		SEL_CONTROL = 3'b001,
		SEL_LOW = 3'b010,
		SEL_HIGH = 3'b011,
		SEL_FLAG = 3'b100,
		SEL_ENABLE = 3'b101,
		SEL_GLOBAL = 3'b110
	} reg_sel_t;

	typedef struct packed {
		timer_ctrl_t ctrl;
		logic [15:0] count;
		logic [2:0] pre_cnt;
		logic [1:0] phase;
		logic gate;
		logic rollover_flag;
		logic rollover_interrupt_enable;
		logic peripheral_interrupt_enable;
		logic global_interrupt_enable;
		bus_req_t req;
		logic [31:0] rdata;
		logic ready;
		logic resp;
		logic irq;
	} timer_state_t;

endpackage : interval_timer_pkg

/* tb_top.sv */
`timescale 1ns/10ps
`include "interval_timer_cfg.svh"
module tb_top;
	logic clk = 0, rst_b = 0, hsel = 0, hwrite = 0, sleep_mode = 0;
	logic [7:0] haddr = 0;
	logic [1:0] htrans = 0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] hwdata = 0, hrdata, d, c1;
	logic hready, hresp, irq;
	int miscompares, checks;
	int mdl[8];
	always #5 clk = ~clk;
	interval_timer u_interval_timer (
		.clk(clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hready), .hrdata(hrdata), .hreadyout(hready),
		.hresp(hresp), .sleep_mode(sleep_mode), .irq(irq)
	);
	task conclude;
		$display("miscompares=%0d checks=%0d", miscompares, checks);
		if (miscompares == 0 && checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : conclude
	task cmp_reg(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			miscompares++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : cmp_reg
	task cmp_irq(input logic got, input logic exp);
		checks++;
		if (got !== exp) begin
			miscompares++;
			$display("unexpected irq at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : cmp_irq
	// bounded wait for hready at a rising edge
	task wait_rdy;
		int n;
		n = 0;
		@(posedge clk);
		while (hready !== 1'b1) begin
			n++;
			if (n > 50) begin
				miscompares++;
				conclude;
			end
			@(posedge clk);
		end
	endtask : wait_rdy
	task wr(input logic [7:0] a, input logic [31:0] v);
		hsel <= 1'b1;
		haddr <= a;
		hwrite <= 1'b1;
		htrans <= 2'b10;
		wait_rdy;
		htrans <= 2'b00;
		hsel <= 1'b0;
		hwdata <= v;
		wait_rdy;
		case (a)
			`OFS_CONTROL: mdl[0] = v & 32'h0000_0033;
			`OFS_COUNT_LOW: mdl[1] = v & 32'h0000_00FF;
			`OFS_COUNT_HIGH: mdl[2] = v & 32'h0000_00FF;
			`OFS_FLAG: if (v[0]) mdl[3] = 0;
			`OFS_ENABLE: mdl[4] = v & 32'h0000_0001;
			`OFS_GLOBAL: mdl[5] = v & 32'h0000_00C0;
			default: ;
		endcase
	endtask : wr
	task rd(input logic [7:0] a, output logic [31:0] v);
		hsel <= 1'b1;
		haddr <= a;
		hwrite <= 1'b0;
		htrans <= 2'b10;
		wait_rdy;
		htrans <= 2'b00;
		hsel <= 1'b0;
		wait_rdy;
		v = hrdata;
		cmp_reg({31'h0000_0000, hresp}, 32'h0000_0000);
	endtask : rd
	// low byte over n cycles between two address phases; n divides evenly
	task rate(input int n, input int stp);
		rd(`OFS_COUNT_LOW, c1);
		repeat (n - 2) @(posedge clk);
		rd(`OFS_COUNT_LOW, d);
		cmp_reg(d, (c1 + stp) & 32'h0000_00FF);
	endtask : rate
	initial begin
		#200000;
		miscompares++;
		conclude;
	end
	initial begin
		void'($urandom(56000));
		repeat (6) @(posedge clk);
		rst_b <= 1'b1;
		for (int i = 0; i < 7; i++) begin
			rd(8'(i * 4), d);
			cmp_reg(d, 32'h0000_0000);
		end
		wr(`OFS_CONTROL, 32'hFFFF_FFFF);
		rd(`OFS_CONTROL, d);
		cmp_reg(d, mdl[0]);
		wr(`OFS_CONTROL, 32'h0000_0000);
		for (int i = 0; i < 4; i++) begin
			wr(i[0] ? `OFS_COUNT_HIGH : `OFS_COUNT_LOW, $urandom);
			rd(`OFS_COUNT_LOW, d);
			cmp_reg(d, mdl[1]);
			rd(`OFS_COUNT_HIGH, d);
			cmp_reg(d, mdl[2]);
		end
		// unmapped word must stay zero after a write
		wr(8'h18, 32'hFFFF_FFFF);
		rd(8'h18, d);
		cmp_reg(d, 32'h0000_0000);
		// 1:8 from the system clock: first step lands eight edges on
		wr(`OFS_CONTROL, 32'h0000_0033);
		repeat (3) @(posedge clk);
		wr(`OFS_COUNT_LOW, 32'h0000_0040);
		repeat (5) @(posedge clk);
		rd(`OFS_COUNT_LOW, d);
		cmp_reg(d, 32'h0000_0040);
		repeat (2) @(posedge clk);
		rd(`OFS_COUNT_LOW, d);
		cmp_reg(d, 32'h0000_0041);
		for (int cs = 0; cs < 2; cs++)
			for (int ps = 0; ps < 4; ps++) begin
				wr(`OFS_CONTROL, (ps << 4) | (cs << 1) | 1);
				// restart the prescaler so a stale count cannot stall the window
				wr(`OFS_COUNT_LOW, $urandom);
				rate(64, cs ? (64 >> ps) : (16 >> ps));
			end
		wr(`OFS_CONTROL, 32'h0000_0002);
		rate(64, 0);
		wr(`OFS_CONTROL, 32'h0000_0003);
		sleep_mode <= 1'b1;
		rate(64, 0);
		sleep_mode <= 1'b0;
		wr(`OFS_CONTROL, 32'h0000_0000);
		wr(`OFS_COUNT_HIGH, 32'h0000_00FF);
		wr(`OFS_COUNT_LOW, 32'h0000_00F0);
		wr(`OFS_FLAG, 32'h0000_0001); // flag cleared before enables
		rd(`OFS_FLAG, d);
		cmp_reg(d, mdl[3]);
		wr(`OFS_ENABLE, 32'h0000_0001);
		wr(`OFS_GLOBAL, 32'h0000_00C0);
		cmp_irq(irq, 1'b0);
		wr(`OFS_CONTROL, 32'h0000_0003);
		// gate opens one cycle after on, so the first edge gives no step
		rate(64, 63);
		rd(`OFS_COUNT_HIGH, d);
		cmp_reg(d, 32'h0000_0000);
		mdl[3] = 1;
		rd(`OFS_FLAG, d);
		cmp_reg(d, mdl[3]);
		cmp_irq(irq, 1'b1);
		for (int i = 0; i < 8; i++) begin
			wr(`OFS_ENABLE, i & 1);
			wr(`OFS_GLOBAL, (i & 6) << 5);
			repeat (2) @(posedge clk);
			cmp_irq(irq, i == 7);
		end
		wr(`OFS_CONTROL, 32'h0000_0000);
		repeat (2) @(posedge clk);
		cmp_irq(irq, 1'b0);
		wr(`OFS_CONTROL, 32'h0000_0003);
		wr(`OFS_FLAG, 32'h0000_0001);
		repeat (2) @(posedge clk);
		cmp_irq(irq, 1'b0);
		rd(`OFS_FLAG, d);
		cmp_reg(d, mdl[3]);
		conclude;
	end
endmodule : tb_top
